// >>> rtl/acc_pkg.sv
/*
  Package for the core calibration controller: register offsets, field positions, reset values, timing counts and
  the state type.
  Assumes a 32-bit APB slave with byte addresses.
*/
package acc_pkg;
  // Register byte offsets
  localparam logic [11:0] ACC_OFS_CTRL       = 12'h000;  // Control bits
  localparam logic [11:0] ACC_OFS_STATUS     = 12'h004;  // Status bits
  localparam logic [11:0] ACC_OFS_TRIM_IDX   = 12'h008;  // Trim table index
  localparam logic [11:0] ACC_OFS_TRIM_DATA  = 12'h00c;  // Trim table data
  // Delay registers sit at word indices; the bus sees four times the index
  localparam logic [11:0] ACC_IDX_SRC_DLY    = 12'h09a;  // Core source delay word index
  localparam logic [11:0] ACC_IDX_MUX_DLY    = 12'h09b;  // Output mux delay word index
  localparam logic [11:0] ACC_OFS_SRC_DLY    = {ACC_IDX_SRC_DLY[9:0], 2'b00};  // Core source delay
  localparam logic [11:0] ACC_OFS_MUX_DLY    = {ACC_IDX_MUX_DLY[9:0], 2'b00};  // Output mux delay

  // Control field positions
  localparam int ACC_CTRL_SOFT_TRIG = 0;  // Software calibrate bit
  localparam int ACC_CTRL_TRIG_SRC  = 1;  // Trigger source select, 1 = pin
  localparam int ACC_CTRL_BG_EN     = 2;  // Background mode enable

  // Status field positions
  localparam int ACC_STAT_FG_BUSY   = 0;  // Foreground running
  localparam int ACC_STAT_FG_DONE   = 1;  // Foreground completed
  localparam int ACC_STAT_BG_ACTIVE = 2;  // Background rotation running

  // Reset values
  localparam logic [7:0] ACC_RST_CTRL    = 8'h00;
  localparam logic [7:0] ACC_RST_SRC_DLY = 8'h00;
  localparam logic [7:0] ACC_RST_MUX_DLY = 8'h00;

  // Timing: clock and calibration durations
  localparam int ACC_CLK_MHZ     = 200;
  localparam int ACC_FG_CAL_US   = 100;   // Foreground run length
  localparam int ACC_BG_CAL_US   = 50;    // One core's background run
  localparam int ACC_FG_CYC      = ACC_FG_CAL_US * ACC_CLK_MHZ;
  localparam int ACC_BG_CYC      = ACC_BG_CAL_US * ACC_CLK_MHZ;

  // Geometry
  localparam int ACC_NCORE = 6;
  localparam int ACC_NIN   = 4;
  localparam int ACC_NTRIM = 3;  // Offset, gain, termination

  // Sequencer states
  typedef enum logic [1:0] {
    ACC_ST_IDLE,
    ACC_ST_FG,
    ACC_ST_BG
  } acc_state_t;
endpackage : acc_pkg

// >>> rtl/acc_trim_mem.sv
/*
  Trim value memory: one word per input, core and parameter.
  Assumes a synchronous write port; read data comes from a register.
*/
`timescale 1ns/1ps
module acc_trim_mem
  import acc_pkg::*;
#(
  parameter int AW = 6,
  parameter int DW = 8,
  parameter int DEPTH = 64
)(
  input  wire logic          i_clk,
  input  wire logic          i_arst_n,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_addr,
  input  wire logic [DW-1:0] i_wdata,
  input  wire logic [DW-1:0] i_fuse [DEPTH],
  input  wire logic          i_load,
  output logic      [DW-1:0] o_rdata
);
  logic [DW-1:0] mem_ff [DEPTH];  // Trim storage
  logic [DW-1:0] nxt_rdata;       // Read word ahead of its register

  // Read path
  always_comb
  begin
    nxt_rdata = mem_ff[i_addr];
  end

  // Storage; factory values load after reset, writes override
  always_ff @(posedge i_clk)
  begin
    for (int k = 0; k < DEPTH; k++)
    begin
      if (i_load)
        mem_ff[k] <= i_fuse[k];
      else if (i_we && i_addr == AW'(k))
        mem_ff[k] <= i_wdata;
    end
  end

  // Registered read data
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_rdata <= '0;
    else
      o_rdata <= nxt_rdata;
  end
endmodule : acc_trim_mem

// >>> rtl/acc_cal_ctrl.sv
/*
  Calibration sequencer for six conversion cores feeding four channels, with APB register access and trim table.
  Assumes a single 200 MHz clock, factory trims on i_fuse_trim, and core data from the analog side.
*/
// The implementer's own choice: the APB interface to the registers.
// Overview of operation
// - Foreground run forces mid-code on all channels
// - Six cores; 0,1,4,5 feed inputs A-D
// - Spare 2 covers 0/1, 3 covers 4/5
// - Each run trims linearity, gain, offset
// - Foreground run starts after reset automatically
// - Trigger from pin or software bit
// - Background mode never interrupts output data
// - Calibrated core returns to its channel, spare covers next, rotating forever
// - Only one core calibrated at once in background; foreground calibrates all six
// - Trims load factory values, readable, writable
// - One trim per input and core
`timescale 1ns/1ps
module acc_cal_ctrl
  import acc_pkg::*;
#(
  parameter int DW        = 12,
  parameter int TW        = 8,
  parameter int FG_CYCLES = ACC_FG_CYC,
  parameter int BG_CYCLES = ACC_BG_CYC
)(
  input  wire logic          i_clk,
  input  wire logic          i_arst_n,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // Trigger pin, asynchronous
  input  wire logic          i_hw_calibrate_pin,
  // Core data and factory trims
  input  wire logic [DW-1:0] i_core_data [ACC_NCORE],
  input  wire logic [TW-1:0] i_fuse_trim [64],
  // Outputs
  output logic      [DW-1:0] o_chan_data [ACC_NIN],
  output logic      [ACC_NCORE-1:0] o_core_online,
  output logic      [ACC_NCORE-1:0] o_core_cal,
  output logic      [7:0]    o_core_source_delay,
  output logic      [7:0]    o_output_mux_delay,
  output logic               o_fg_done
);
  localparam logic [31:0] FG_N = 32'(FG_CYCLES);
  localparam logic [31:0] BG_N = 32'(BG_CYCLES);

  // Control, state and counters
  logic [7:0]   ctrl_ff, nxt_ctrl;          // Control register
  logic [7:0]   src_dly_ff, nxt_src_dly;    // Core source delay
  logic [7:0]   mux_dly_ff, nxt_mux_dly;    // Output mux delay
  logic [5:0]   tidx_ff, nxt_tidx;          // Trim index
  acc_state_t   st_ff, nxt_st;              // Sequencer state
  logic [31:0]  cnt_ff, nxt_cnt;            // Run length counter
  logic [1:0]   slot_ff, nxt_slot;          // Rotation position 0..3
  logic         done_ff, nxt_done;          // Foreground done flag
  logic         boot_ff, nxt_boot;          // Power-up run pending
  logic         load_ff, nxt_load;          // Trim load after reset
  logic         trig_q_ff, nxt_trig_q;      // Trigger level delayed
  logic [1:0]   pin_sync_ff;                // Pin synchroniser
  logic [DW-1:0] chan_ff [ACC_NIN];         // Output data registers
  logic [DW-1:0] nxt_chan [ACC_NIN];
  logic [TW-1:0] trim_rdata;                // Trim memory read
  logic         trig_lvl, trig_rise;        // Selected trigger
  logic         wr_en, rd_en, trim_we;      // Bus strobes
  logic [31:0]  nxt_prdata;
  logic [2:0]   cal_core;                   // Core under calibration
  logic [2:0]   spare_core;                 // Spare standing in for it

  // Pin synchroniser; only second stage is read
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      pin_sync_ff <= 2'b00;
    else
      pin_sync_ff <= {pin_sync_ff[0], i_hw_calibrate_pin};
  end

  // Bus strobes; slave always answers in the access cycle
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && !penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign trim_we = wr_en && paddr == ACC_OFS_TRIM_DATA;

  assign trig_lvl  = ctrl_ff[ACC_CTRL_TRIG_SRC] ? pin_sync_ff[1] : ctrl_ff[ACC_CTRL_SOFT_TRIG];
  assign trig_rise = trig_lvl && !trig_q_ff;

  // Register next values
  always_comb
  begin
    nxt_ctrl    = ctrl_ff;
    nxt_src_dly = src_dly_ff;
    nxt_mux_dly = mux_dly_ff;
    nxt_tidx    = tidx_ff;
    if (wr_en)
    begin
      case (paddr)
        ACC_OFS_CTRL:     nxt_ctrl    = pwdata[7:0];
        ACC_OFS_TRIM_IDX: nxt_tidx    = pwdata[5:0];
        ACC_OFS_SRC_DLY:  nxt_src_dly = pwdata[7:0];
        ACC_OFS_MUX_DLY:  nxt_mux_dly = pwdata[7:0];
        default:          nxt_ctrl    = ctrl_ff;
      endcase
    end
  end

  // Read data, latched in setup so it stands through access
  always_comb
  begin
    nxt_prdata = prdata;
    if (rd_en)
    begin
      case (paddr)
        ACC_OFS_CTRL:      nxt_prdata = {24'h000000, ctrl_ff};
        ACC_OFS_STATUS:    nxt_prdata = {29'h0, st_ff == ACC_ST_BG, done_ff, st_ff == ACC_ST_FG};
        ACC_OFS_TRIM_IDX:  nxt_prdata = {26'h0, tidx_ff};
        ACC_OFS_TRIM_DATA: nxt_prdata = {24'h000000, trim_rdata};
        ACC_OFS_SRC_DLY:   nxt_prdata = {24'h000000, src_dly_ff};
        ACC_OFS_MUX_DLY:   nxt_prdata = {24'h000000, mux_dly_ff};
        default:           nxt_prdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      ctrl_ff    <= ACC_RST_CTRL;
      src_dly_ff <= ACC_RST_SRC_DLY;
      mux_dly_ff <= ACC_RST_MUX_DLY;
      tidx_ff    <= 6'h00;
      prdata     <= 32'h00000000;
    end
    else
    begin
      ctrl_ff    <= nxt_ctrl;
      src_dly_ff <= nxt_src_dly;
      mux_dly_ff <= nxt_mux_dly;
      tidx_ff    <= nxt_tidx;
      prdata     <= nxt_prdata;
    end
  end

  // Sequencer next state
  always_comb
  begin
    nxt_st     = st_ff;
    nxt_cnt    = cnt_ff;
    nxt_slot   = slot_ff;
    nxt_done   = done_ff;
    nxt_boot   = 1'b0;
    nxt_load   = 1'b0;
    nxt_trig_q = trig_lvl;
    case (st_ff)
      ACC_ST_IDLE:
      begin
        if (boot_ff || trig_rise)
        begin
          nxt_st   = ACC_ST_FG;
          nxt_cnt  = 32'h0;
          nxt_done = 1'b0;
        end
        // background needs enable, source 0, trigger 1
        else if (ctrl_ff[ACC_CTRL_BG_EN] && !ctrl_ff[ACC_CTRL_TRIG_SRC] && ctrl_ff[ACC_CTRL_SOFT_TRIG])
        begin
          nxt_st  = ACC_ST_BG;
          nxt_cnt = 32'h0;
        end
      end
      ACC_ST_FG:
      begin
        if (cnt_ff == FG_N - 32'h1)
        begin
          nxt_st   = ACC_ST_IDLE;
          // completion flag, cleared when the next foreground run starts
          nxt_done = 1'b1;
        end
        else
          nxt_cnt = cnt_ff + 32'h1;
      end
      ACC_ST_BG:
      begin
        if (!(ctrl_ff[ACC_CTRL_BG_EN] && ctrl_ff[ACC_CTRL_SOFT_TRIG]))
          nxt_st = ACC_ST_IDLE;
        // finished core returns to its channel, next rotates out
        else if (cnt_ff == BG_N - 32'h1)
        begin
          nxt_cnt  = 32'h0;
          nxt_slot = slot_ff + 2'd1;
        end
        else
          nxt_cnt = cnt_ff + 32'h1;
      end
      default:
        nxt_st = ACC_ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      st_ff     <= ACC_ST_IDLE;
      cnt_ff    <= 32'h0;
      slot_ff   <= 2'd0;
      done_ff   <= 1'b0;
      boot_ff   <= 1'b1;
      load_ff   <= 1'b1;
      trig_q_ff <= 1'b0;
    end
    else
    begin
      st_ff     <= nxt_st;
      cnt_ff    <= nxt_cnt;
      slot_ff   <= nxt_slot;
      done_ff   <= nxt_done;
      boot_ff   <= nxt_boot;
      load_ff   <= nxt_load;
      trig_q_ff <= nxt_trig_q;
    end
  end

  // a single calibrating core per rotation slot
  // slots 0,1 spare 2 covers; slots 2,3 spare 3 covers
  always_comb
  begin
    case (slot_ff)
      2'd0:    cal_core = 3'd0;
      2'd1:    cal_core = 3'd1;
      2'd2:    cal_core = 3'd4;
      default: cal_core = 3'd5;
    endcase
  end

  // slots 2,3 belong to the second pair
  assign spare_core = slot_ff[1] ? 3'd3 : 3'd2;

  // Output mux per channel
  for (genvar c = 0; c < ACC_NIN; c++)
  begin : g_chan
    localparam logic [2:0] HOME  = (c < 2) ? 3'(c) : 3'(c + 2);
    localparam logic [2:0] SPARE = (c < 2) ? 3'd2 : 3'd3;
    always_comb
    begin
      if (st_ff == ACC_ST_FG)
        nxt_chan[c] = '0;
      else if (st_ff == ACC_ST_BG && cal_core == HOME)
        nxt_chan[c] = i_core_data[SPARE];
      else
        nxt_chan[c] = i_core_data[HOME];
    end
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
      if (!i_arst_n)
        chan_ff[c] <= '0;
      else
        chan_ff[c] <= nxt_chan[c];
    end
    assign o_chan_data[c] = chan_ff[c];
  end

  // Core online and calibrating flags
  always_comb
  begin
    o_core_online = 6'b110011;
    o_core_cal    = 6'b000000;
    if (st_ff == ACC_ST_FG)
    begin
      o_core_online = 6'b000000;
      o_core_cal    = 6'b111111;
    end
    else if (st_ff == ACC_ST_BG)
    begin
      // spare swaps in, other spare stays idle
      o_core_online[cal_core]   = 1'b0;
      o_core_online[spare_core] = 1'b1;
      o_core_cal[cal_core]      = 1'b1;
    end
  end

  assign o_core_source_delay = src_dly_ff;
  assign o_output_mux_delay  = mux_dly_ff;
  assign o_fg_done           = done_ff;

  // one word per input, core and parameter
  acc_trim_mem #(
    .AW    (6),
    .DW    (TW),
    .DEPTH (64)
  ) u_trim (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_we     (trim_we),
    .i_addr   (tidx_ff),
    .i_wdata  (pwdata[TW-1:0]),
    .i_fuse   (i_fuse_trim),
    .i_load   (load_ff),
    .o_rdata  (trim_rdata)
  );
endmodule : acc_cal_ctrl

// >>> testbench/acc_cal_ctrl_assertions.sv
/*
  Checker for the calibration sequencer ports.
  Assumes one clock domain and the active-low asynchronous reset.
*/
`timescale 1ns/1ps
module acc_cal_chk
  import acc_pkg::*;
#(
  parameter int DW = 12
)(
  input  wire logic                 i_clk,
  input  wire logic                 i_arst_n,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pready,
  input  wire logic                 pslverr,
  input  wire logic [DW-1:0]        o_chan_data [ACC_NIN],
  input  wire logic [ACC_NCORE-1:0] o_core_online,
  input  wire logic [ACC_NCORE-1:0] o_core_cal,
  input  wire logic                 o_fg_done
);
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);
  // Foreground: no core feeds output
  wire fg   = (o_core_online == 6'h00);
  // Some core is feeding output
  wire live = (o_core_online != 6'h00);
  // Any channel away from mid-code
  wire nz   = |{o_chan_data[0], o_chan_data[1], o_chan_data[2], o_chan_data[3]};

  property p_mid;
    fg && $past(fg) |-> !nz;
  endproperty
  a_mid: assert property (p_mid) else $error("channel not mid-code");
  property p_boot;
    $rose(i_arst_n) |-> ##[0:3] fg;
  endproperty
  a_boot: assert property (p_boot) else $error("no run after reset");
  property p_one;
    live |-> $onehot0(o_core_cal);
  endproperty
  a_one: assert property (p_one) else $error("two cores in calibration");
  property p_four;
    live |-> $countones(o_core_online) == 4;
  endproperty
  a_four: assert property (p_four) else $error("channel left unserved");
  property p_sp01;
    live && (|o_core_cal[1:0]) |-> o_core_online[2];
  endproperty
  a_sp01: assert property (p_sp01) else $error("spare 2 not standing in");
  property p_sp45;
    live && (|o_core_cal[5:4]) |-> o_core_online[3];
  endproperty
  a_sp45: assert property (p_sp45) else $error("spare 3 not standing in");
  property p_done;
    $rose(o_fg_done) |-> $past(fg);
  endproperty
  a_done: assert property (p_done) else $error("done without run");
  property p_busy;
    fg && $past(fg) |-> !o_fg_done;
  endproperty
  a_busy: assert property (p_busy) else $error("done during run");
  property p_apb;
    psel && penable |-> pready && !pslverr;
  endproperty
  a_apb: assert property (p_apb) else $error("bus access refused");
endmodule : acc_cal_chk

bind acc_cal_ctrl acc_cal_chk #(.DW(DW)) u_chk (
  .i_clk(i_clk),
  .i_arst_n(i_arst_n),
  .psel(psel),
  .penable(penable),
  .pready(pready),
  .pslverr(pslverr),
  .o_chan_data(o_chan_data),
  .o_core_online(o_core_online),
  .o_core_cal(o_core_cal),
  .o_fg_done(o_fg_done)
);

// >>> testbench/testbench.sv
/*
  Self-checking bench for the calibration sequencer, driven over APB.
  Assumes the bound checker and shortened run lengths.
*/
`timescale 1ns/1ps
module testbench
  import acc_pkg::*;
;
  localparam int FGC = 20;       // Short foreground run
  localparam int BGC = 10;       // Short per-core run
  logic        i_clk;
  logic        i_arst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pin;              // Trigger pin
  logic [11:0] core_d [ACC_NCORE];
  logic [7:0]  fuse [64];        // Factory trims
  logic [11:0] chan [ACC_NIN];
  logic [5:0]  online;
  logic [5:0]  cal;
  logic [7:0]  src_dly;
  logic [7:0]  mux_dly;
  logic        done;
  logic [31:0] r;                // Last read word
  logic [5:0]  seen;             // Cores seen calibrating
  logic        bad;              // Output gap seen
  int          n_mismatch = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          map [4] = '{0, 1, 4, 5};

  acc_cal_ctrl #(.FG_CYCLES(FGC), .BG_CYCLES(BGC)) DUT (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .i_hw_calibrate_pin(pin),
    .i_core_data(core_d), .i_fuse_trim(fuse), .o_chan_data(chan),
    .o_core_online(online), .o_core_cal(cal), .o_core_source_delay(src_dly),
    .o_output_mux_delay(mux_dly), .o_fg_done(done));

  // Free-running clock
  initial
  begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  task chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  // Setup cycle, then access until pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    do @(posedge i_clk); while (pready !== 1'b1);
    r = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Wait for a run, then its end
  task run_fg;
    int n;
    n = 0;
    while (online !== 6'h00) @(negedge i_clk);
    repeat (2) @(negedge i_clk);
    chk(32'(chan[2]), 32'h0);
    while (done !== 1'b1)
    begin
      @(negedge i_clk);
      n++;
    end
    chk(32'(n), 32'(FGC - 2));
  endtask : run_fg

  task close_out;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out

  // Hang guard, far above the expected run
  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_mismatch++;
      close_out();
    end
  end

  initial
  begin
    i_arst_n = 1'b0;
    {psel, penable, pwrite, pin} = 4'h0;
    paddr  = 12'h000;
    pwdata = 32'h0;
    for (int k = 0; k < 64; k++) fuse[k] = 8'(k * 3 + 1);
    for (int k = 0; k < 6; k++) core_d[k] = 12'h100 + 12'(k);
    repeat (12) @(posedge i_clk);
    chk(32'(online), 32'h33);
    i_arst_n <= 1'b1;
    // host waits for the power-up run
    run_fg();
    // Channel registers refill one cycle after the run ends
    @(negedge i_clk);
    for (int k = 0; k < 4; k++) chk(32'(chan[k]), 32'(core_d[map[k]]));
    $display("test boot ended");
    // Delay registers, unmapped write
    apb(1'b0, ACC_OFS_SRC_DLY, 32'h0);
    chk(r, 32'(ACC_RST_SRC_DLY));
    apb(1'b1, ACC_OFS_SRC_DLY, 32'h1f);
    apb(1'b1, ACC_OFS_MUX_DLY, 32'h1e);
    apb(1'b1, 12'h100, 32'hff);
    apb(1'b0, ACC_OFS_SRC_DLY, 32'h0);
    chk(r, 32'h1f);
    apb(1'b0, ACC_OFS_MUX_DLY, 32'h0);
    chk(r, 32'h1e);
    apb(1'b0, 12'h100, 32'h0);
    chk(r, 32'h0);
    chk(32'({src_dly, mux_dly}), 32'h1f1e);
    // Trim table: factory value, override, neighbour
    apb(1'b1, ACC_OFS_TRIM_IDX, 32'h7);
    apb(1'b0, ACC_OFS_TRIM_DATA, 32'h0);
    chk(r, 32'(fuse[7]));
    apb(1'b1, ACC_OFS_TRIM_DATA, 32'ha5);
    apb(1'b1, ACC_OFS_TRIM_IDX, 32'h8);
    apb(1'b0, ACC_OFS_TRIM_DATA, 32'h0);
    chk(r, 32'(fuse[8]));
    apb(1'b1, ACC_OFS_TRIM_IDX, 32'h7);
    apb(1'b0, ACC_OFS_TRIM_DATA, 32'h0);
    chk(r, 32'ha5);
    $display("test registers ended");
    apb(1'b1, ACC_OFS_CTRL, 32'h1);
    run_fg();
    apb(1'b1, ACC_OFS_CTRL, 32'h0);
    // Pin must be ignored while software selected
    @(posedge i_clk);
    pin <= 1'b1;
    repeat (8) @(posedge i_clk);
    pin <= 1'b0;
    @(negedge i_clk);
    chk(32'({done, online}), 32'h73);
    apb(1'b1, ACC_OFS_CTRL, 32'h2);
    @(posedge i_clk);
    pin <= 1'b1;
    run_fg();
    @(posedge i_clk);
    pin <= 1'b0;
    apb(1'b1, ACC_OFS_CTRL, 32'h0);
    $display("test triggers ended");
    // background entry: enable, source 0, trigger 1
    apb(1'b1, ACC_OFS_CTRL, 32'h4);
    apb(1'b1, ACC_OFS_CTRL, 32'h5);
    run_fg();
    seen = 6'h00;
    bad  = 1'b0;
    repeat (3) @(negedge i_clk);
    repeat (12 * BGC)
    begin
      @(negedge i_clk);
      seen = seen | cal;
      bad  = bad | (chan[0] === 12'h000) | (chan[3] === 12'h000);
    end
    chk(32'(seen), 32'h33);
    chk(32'(bad), 32'h0);
    apb(1'b0, ACC_OFS_STATUS, 32'h0);
    chk(32'(r[2:0]), 32'h6);
    apb(1'b1, ACC_OFS_CTRL, 32'h0);
    repeat (2 * BGC) @(negedge i_clk);
    chk(32'({cal, online}), 32'h33);
    $display("test background ended");
    // second reset: run again, registers back
    @(posedge i_clk);
    i_arst_n <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_arst_n <= 1'b1;
    run_fg();
    apb(1'b0, ACC_OFS_SRC_DLY, 32'h0);
    chk(r, 32'(ACC_RST_SRC_DLY));
    $display("test rereset ended");
    close_out();
  end
endmodule : testbench
